// >>> hw/slpg_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "slpg_map.vh"

module slpg_engine #(
    parameter [`SLPG_PRESC_W-1:0] TICK_CYCLES = `SLPG_PRESC_ONE
) (
    input wire core_clk,
    input wire rst_b,
    input wire [3:0] pattern,
    output reg red,
    output reg green
);

    reg [3:0] last_pattern;
    reg [`SLPG_PRESC_W-1:0] presc;
    reg [4:0] phase;
    reg [`SLPG_PRESC_W-1:0] next_presc;
    reg [4:0] next_phase;
    reg [4:0] last_phase;
    reg next_red;
    reg next_green;
    reg first_half;

    // ************************************************************
    // Phase sequencing
    // ************************************************************
    // Each indicator owns its prescaler so a restart gives a full first phase.
    always @* begin
        case (pattern)
            `SLPG_PAT_RED_FAST, `SLPG_PAT_ALT_FAST: last_phase = `SLPG_FAST_LAST;
            `SLPG_PAT_RED_SLOW, `SLPG_PAT_GREEN_SLOW,
            `SLPG_PAT_ALT_SLOW: last_phase = `SLPG_SLOW_LAST;
            `SLPG_PAT_GREEN_DOUBLE, `SLPG_PAT_RED_DOUBLE: last_phase = `SLPG_DOUBLE_LAST;
            `SLPG_PAT_GREEN_TRIPLE, `SLPG_PAT_RED_TRIPLE: last_phase = `SLPG_TRIPLE_LAST;
            default: last_phase = `SLPG_STEADY_LAST;
        endcase
        if (pattern != last_pattern) begin
            next_presc = `SLPG_PRESC_ZERO;
            next_phase = `SLPG_PH_ZERO;
        end else if (presc == TICK_CYCLES - `SLPG_PRESC_ONE) begin
            next_presc = `SLPG_PRESC_ZERO;
            if (phase >= last_phase) begin
                next_phase = `SLPG_PH_ZERO;
            end else begin
                next_phase = phase + `SLPG_PH_ONE;
            end
        end else begin
            next_presc = presc + `SLPG_PRESC_ONE;
            next_phase = phase;
        end
    end

    // ************************************************************
    // Pattern shapes
    // ************************************************************
    always @* begin
        first_half = ~next_phase[1];
        next_red = 1'b0;
        next_green = 1'b0;
        case (pattern)
            `SLPG_PAT_RED_ON: next_red = 1'b1;
            `SLPG_PAT_GREEN_ON: next_green = 1'b1;
            `SLPG_PAT_RED_FAST: next_red = ~next_phase[0];
            `SLPG_PAT_RED_SLOW: next_red = first_half;
            `SLPG_PAT_GREEN_SLOW: next_green = first_half;
            `SLPG_PAT_ALT_SLOW: begin
                next_red = first_half;
                next_green = ~first_half;
            end
            `SLPG_PAT_ALT_FAST: begin
                next_red = ~next_phase[0];
                next_green = next_phase[0];
            end
            `SLPG_PAT_GREEN_DOUBLE: begin
                next_green = first_half && (next_phase < `SLPG_DOUBLE_ON_END);
            end
            `SLPG_PAT_RED_DOUBLE: begin
                next_red = first_half && (next_phase < `SLPG_DOUBLE_ON_END);
            end
            `SLPG_PAT_GREEN_TRIPLE: begin
                next_green = first_half && (next_phase < `SLPG_TRIPLE_ON_END);
            end
            `SLPG_PAT_RED_TRIPLE: begin
                next_red = first_half && (next_phase < `SLPG_TRIPLE_ON_END);
            end
            default: begin
                next_red = 1'b0;
                next_green = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_pattern <= `SLPG_PAT_OFF;
            presc <= `SLPG_PRESC_ZERO;
            phase <= `SLPG_PH_ZERO;
            red <= 1'b0;
            green <= 1'b0;
        end else begin
            last_pattern <= pattern;
            presc <= next_presc;
            phase <= next_phase;
            red <= next_red;
            green <= next_green;
        end
    end

endmodule
`default_nettype wire

// >>> hw/slpg_map.vh
`ifndef SLPG_MAP_VH
`define SLPG_MAP_VH

// ************************************************************
// Timebase
// ************************************************************
`define SLPG_CLK_MHZ 200
`define SLPG_TICK_MS 125
`define SLPG_US_PER_MS 1000
`define SLPG_PRESC_W 25
`define SLPG_PRESC_ZERO 25'h0000000
`define SLPG_PRESC_ONE 25'h0000001
// One tick is 125 ms of a 200 MHz clock, sized to the prescaler width.
`define SLPG_TICK_CYCLES 25'h17D7840

// ************************************************************
// Phase counts, in 125 ms ticks
// ************************************************************
`define SLPG_PH_ZERO 5'h00
`define SLPG_PH_ONE 5'h01
`define SLPG_STEADY_LAST 5'h00
`define SLPG_FAST_LAST 5'h01
`define SLPG_SLOW_LAST 5'h03
`define SLPG_DOUBLE_LAST 5'h0F
`define SLPG_DOUBLE_ON_END 5'h08
`define SLPG_TRIPLE_LAST 5'h13
`define SLPG_TRIPLE_ON_END 5'h0C

// ************************************************************
// Pattern codes
// ************************************************************
`define SLPG_PAT_OFF 4'h0
`define SLPG_PAT_RED_ON 4'h1
`define SLPG_PAT_GREEN_ON 4'h2
`define SLPG_PAT_RED_FAST 4'h3
`define SLPG_PAT_RED_SLOW 4'h4
`define SLPG_PAT_GREEN_SLOW 4'h5
`define SLPG_PAT_ALT_SLOW 4'h6
`define SLPG_PAT_ALT_FAST 4'h7
`define SLPG_PAT_GREEN_DOUBLE 4'h8
`define SLPG_PAT_RED_DOUBLE 4'h9
`define SLPG_PAT_GREEN_TRIPLE 4'hA
`define SLPG_PAT_RED_TRIPLE 4'hB

// ************************************************************
// Module and channel state codes
// ************************************************************
`define SLPG_MOD_RUN 2'h0
`define SLPG_MOD_INIT 2'h1
`define SLPG_MOD_CALIB 2'h2
`define SLPG_MOD_CONFIG 2'h3
`define SLPG_CH_DISABLED 3'h0
`define SLPG_CH_ALIGN_UP 3'h1
`define SLPG_CH_ALIGN_DOWN 3'h2
`define SLPG_CH_AT_NULL 3'h3
`define SLPG_CH_NULL_SET 3'h4
`define SLPG_CH_IDLE 3'h5
`define SLPG_CH_ACTIVE 3'h6
`define SLPG_CH_SENSOR_ERR 3'h7

`endif

// >>> hw/slpg_top.v
`timescale 1ns/100ps
`default_nettype none
`include "slpg_map.vh"

module slpg_top #(
    parameter [`SLPG_PRESC_W-1:0] TICK_CYCLES = `SLPG_TICK_CYCLES
) (
    input wire core_clk,
    input wire rst_b,
    input wire [1:0] module_state,
    input wire module_fault,
    input wire stack_fault,
    input wire [2:0] ch0_state,
    input wire [2:0] ch1_state,
    input wire [1:0] led_disable,
    output wire [1:0] led_red,
    output wire [1:0] led_green
);

    // ************************************************************
    // State decode
    // ************************************************************
    // Faults and the init, calibration and config module states take both indicators and hide the channel view.
    function [3:0] slpg_pick;
        input [1:0] mstate;
        input fault;
        input [2:0] cstate;
        input dark;
        begin
            if (fault) begin
                slpg_pick = `SLPG_PAT_RED_ON;
            end else if (mstate == `SLPG_MOD_INIT) begin
                slpg_pick = `SLPG_PAT_GREEN_DOUBLE;
            end else if (mstate == `SLPG_MOD_CALIB) begin
                slpg_pick = `SLPG_PAT_RED_FAST;
            end else if (mstate == `SLPG_MOD_CONFIG) begin
                slpg_pick = `SLPG_PAT_RED_DOUBLE;
            end else if (dark) begin
                slpg_pick = `SLPG_PAT_OFF;
            end else begin
                case (cstate)
                    `SLPG_CH_ALIGN_UP: slpg_pick = `SLPG_PAT_GREEN_TRIPLE;
                    `SLPG_CH_ALIGN_DOWN: slpg_pick = `SLPG_PAT_RED_TRIPLE;
                    `SLPG_CH_AT_NULL: slpg_pick = `SLPG_PAT_ALT_SLOW;
                    `SLPG_CH_NULL_SET: slpg_pick = `SLPG_PAT_ALT_FAST;
                    `SLPG_CH_IDLE: slpg_pick = `SLPG_PAT_GREEN_SLOW;
                    `SLPG_CH_ACTIVE: slpg_pick = `SLPG_PAT_GREEN_ON;
                    `SLPG_CH_SENSOR_ERR: slpg_pick = `SLPG_PAT_RED_SLOW;
                    default: slpg_pick = `SLPG_PAT_OFF;
                endcase
            end
        end
    endfunction

    wire any_fault;
    wire [3:0] pat0;
    wire [3:0] pat1;

    assign any_fault = module_fault | stack_fault;
    assign pat0 = slpg_pick(module_state, any_fault, ch0_state, led_disable[0]);
    assign pat1 = slpg_pick(module_state, any_fault, ch1_state, led_disable[1]);

    // ************************************************************
    // Indicators
    // ************************************************************
    slpg_engine #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_led0 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pattern(pat0),
        .red(led_red[0]),
        .green(led_green[0])
    );

    slpg_engine #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_led1 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pattern(pat1),
        .red(led_red[1]),
        .green(led_green[1])
    );

endmodule
`default_nettype wire

// >>> sim/slpg_props.sv
`timescale 1ns/100ps
`default_nettype none
module slpg_props #(
    parameter [24:0] TICK_CYCLES = 25'h0000001
) (
    input wire core_clk,
    input wire rst_b,
    input wire [1:0] module_state,
    input wire module_fault,
    input wire stack_fault,
    input wire [2:0] ch0_state,
    input wire [2:0] ch1_state,
    input wire [1:0] led_disable,
    input wire [1:0] led_red,
    input wire [1:0] led_green
);
    // ************************************************************
    // Output checks, one edge after the cause
    // ************************************************************
    wire lv = rst_b && !module_fault && !stack_fault;
    wire [3:0] ms = {4{lv}} & (4'h1 << module_state);
    wire c0 = ms[0] && !led_disable[0];
    wire d1 = ms[0] && led_disable[1];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_fault_red: assert property (
        $past(rst_b) && $past(module_fault) |-> led_red == 2'h3 && led_green == 2'h0)
        else $error("Module fault is not steady red.");
    a_stack_red: assert property (
        $past(rst_b) && $past(stack_fault) |-> led_red == 2'h3 && led_green == 2'h0)
        else $error("Stack fault is not steady red.");
    a_init_no_red: assert property (
        $past(ms[1]) |-> led_red == 2'h0)
        else $error("Red lit while initialized.");
    a_calib_no_green: assert property (
        $past(ms[2]) |-> led_green == 2'h0)
        else $error("Green lit in calibration.");
    a_config_no_green: assert property (
        $past(ms[3]) |-> led_green == 2'h0)
        else $error("Green lit in configuration.");
    a_off_dark: assert property (
        $past(c0) && $past(ch0_state) == 3'h0 |-> led_red[0] == 1'b0 && led_green[0] == 1'b0)
        else $error("Disabled channel is lit.");
    a_active_green: assert property (
        $past(c0) && $past(ch0_state) == 3'h6 |-> led_green[0] && !led_red[0])
        else $error("Measuring channel is not steady green.");
    a_disable_dark: assert property (
        $past(d1) |-> !led_red[1] && !led_green[1])
        else $error("Indicator disable does not darken.");
endmodule
bind slpg_top slpg_props #(.TICK_CYCLES(TICK_CYCLES)) slpg_props_i (.core_clk(core_clk),
    .rst_b(rst_b), .module_state(module_state), .module_fault(module_fault),
    .stack_fault(stack_fault), .ch0_state(ch0_state), .ch1_state(ch1_state),
    .led_disable(led_disable), .led_red(led_red), .led_green(led_green));
`default_nettype wire

// >>> sim/slpg_led_model.sv
`timescale 1ns/100ps
`default_nettype none
module slpg_led_model (
    input wire [1:0] led_red,
    input wire [1:0] led_green,
    output wire [1:0] colour0,
    output wire [1:0] colour1
);
    // Both elements lit reads as amber, which no pattern may ever show.
    assign colour0 = {led_green[0], led_red[0]};
    assign colour1 = {led_green[1], led_red[1]};
endmodule
`default_nettype wire

// >>> sim/slpg_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module slpg_top_test;
    // A short tick keeps each phase at four cycles.
    localparam [24:0] TICK = 25'h0000004;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] module_state = 2'h0;
    logic module_fault = 1'b0;
    logic stack_fault = 1'b0;
    logic [2:0] ch0_state = 3'h0;
    logic [2:0] ch1_state = 3'h0;
    logic [1:0] led_disable = 2'h0;
    wire [1:0] led_red;
    wire [1:0] led_green;
    wire [1:0] colour0;
    wire [1:0] colour1;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 core_clk = ~core_clk;
    slpg_top #(.TICK_CYCLES(TICK)) slpg_top_i (.core_clk(core_clk), .rst_b(rst_b),
        .module_state(module_state), .module_fault(module_fault), .stack_fault(stack_fault),
        .ch0_state(ch0_state), .ch1_state(ch1_state), .led_disable(led_disable),
        .led_red(led_red), .led_green(led_green));
    slpg_led_model slpg_led_model_i (.led_red(led_red), .led_green(led_green),
        .colour0(colour0), .colour1(colour1));
    // Samples sit mid-phase so a one-cycle prescaler offset cannot flip a verdict.
    task automatic run_pat(input [1:0] ms, input [2:0] c0, input [19:0] r, input [19:0] g,
        input both);
        @(posedge core_clk);
        #1;
        module_state = ms;
        ch0_state = c0;
        for (int i = 0; i < 20; i++) begin
            repeat (2) @(posedge core_clk);
            #1;
            `CHK("ch0", {g[i], r[i]}, colour0)
            `CHK("ch1", both ? {g[i], r[i]} : 2'h0, colour1)
            repeat (2) @(posedge core_clk);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #10000;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        run_pat(2'h1, 3'h6, 20'h00000, 20'h30033, 1'b1);
        run_pat(2'h2, 3'h6, 20'h55555, 20'h00000, 1'b1);
        run_pat(2'h3, 3'h6, 20'h30033, 20'h00000, 1'b1);
        run_pat(2'h0, 3'h1, 20'h00000, 20'h00333, 1'b0);
        run_pat(2'h0, 3'h2, 20'h00333, 20'h00000, 1'b0);
        run_pat(2'h0, 3'h3, 20'h33333, 20'hCCCCC, 1'b0);
        run_pat(2'h0, 3'h4, 20'h55555, 20'hAAAAA, 1'b0);
        run_pat(2'h0, 3'h5, 20'h00000, 20'h33333, 1'b0);
        run_pat(2'h0, 3'h6, 20'h00000, 20'hFFFFF, 1'b0);
        run_pat(2'h0, 3'h7, 20'h33333, 20'h00000, 1'b0);
        run_pat(2'h0, 3'h0, 20'h00000, 20'h00000, 1'b0);
        #1;
        module_fault = 1'b1;
        run_pat(2'h1, 3'h5, 20'hFFFFF, 20'h00000, 1'b1);
        #1;
        module_fault = 1'b0;
        stack_fault = 1'b1;
        run_pat(2'h3, 3'h6, 20'hFFFFF, 20'h00000, 1'b1);
        #1;
        stack_fault = 1'b0;
        led_disable = 2'h3;
        ch1_state = 3'h6;
        run_pat(2'h0, 3'h6, 20'h00000, 20'h00000, 1'b1);
        #1;
        led_disable = 2'h0;
        ch1_state = 3'h5;
        run_pat(2'h0, 3'h5, 20'h00000, 20'h33333, 1'b1);
        final_report;
    end
endmodule
`default_nettype wire
